// file: rtl/apt_pkg.sv
// package: register map, field layout, trigger codes and carriers for the pair trigger control
package apt_pkg;

    // register byte offsets on the wishbone slave (word aligned)
    localparam logic [7:0] OFF_CTRL_A = 8'h00;
    localparam logic [7:0] OFF_CTRL_B = 8'h04;
    localparam logic [7:0] OFF_IRQ_STAT = 8'h08;
    localparam logic [7:0] OFF_IRQ_EN = 8'h0C;
    localparam logic [7:0] OFF_IRQ_CLR = 8'h10;
    localparam logic [7:0] OFF_GLOBAL_KICK = 8'h14;

    // geometry
    localparam int NUM_PAIRS = 4;
    localparam logic [3:0] FIRST_PAIR = 4'h2;
    localparam logic [15:0] CTRL_RESET = 16'h0000;
    localparam logic [3:0] IRQ_RESET = 4'h0;
    localparam int GLOBAL_KICK_BIT = 0;

    // trigger source codes
    localparam logic [4:0] SRC_OFF = 5'h00;
    localparam logic [4:0] SRC_SOFT = 5'h01;
    localparam logic [4:0] SRC_GLOBAL = 5'h02;
    localparam logic [4:0] SRC_SPECIAL = 5'h03;
    localparam logic [4:0] SRC_PRI_FIRST = 5'h04;
    localparam logic [4:0] SRC_PRI_LAST = 5'h07;
    localparam logic [4:0] SRC_TIMER1 = 5'h0C;
    localparam logic [4:0] SRC_SEC_FIRST = 5'h0E;
    localparam logic [4:0] SRC_SEC_LAST = 5'h11;
    localparam logic [4:0] SRC_CLIM_FIRST = 5'h17;
    localparam logic [4:0] SRC_CLIM_LAST = 5'h1A;
    localparam logic [4:0] SRC_TIMER2 = 5'h1F;

    // one pair slice, packed as it sits in the register (bit 7 down to bit 0)
    typedef struct packed {
        logic irq_enable;
        logic conv_waiting;
        logic soft_kick;
        logic [4:0] trigger_select;
    } apt_slice_type;

    // trigger sources from the pwm generators and timers, one-cycle pulses
    typedef struct packed {
        logic pwm_special;
        logic [3:0] pwm_primary;
        logic [3:0] pwm_secondary;
        logic [3:0] pwm_climit;
        logic timer1_period;
        logic timer2_period;
    } apt_trig_type;

    // request to the conversion core
    typedef struct packed {
        logic start;
        logic [3:0] pair;
        logic [3:0] chan_hi;
        logic [3:0] chan_lo;
    } apt_conv_type;

    // arbiter states
    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_CONV = 1'b1
    } apt_state_type;

endpackage

// file: rtl/apt_pair_trigger_ctrl.sv
// adc pair trigger control for pairs 2 to 5, wishbone register slave and conversion arbiter
// Behaviour
// - two slices per register: irq, pending, kick, source
// - pair 3 converts inputs 7/6, pair 2 5/4
// - first register low slice selects pair 2 trigger
// - second register high slice drives pair 5 (11/10)
// - irq enable set raises request on completion when the pair's irq_en_ff mask bit is set
// - pending sets on trigger, clears on completion
// - soft kick works only with source code 00001
// - soft kick self-clears as pending sets
// - busy converter keeps request pending until free
// - codes 0-3: off, soft, global, pwm special
// - codes 00100-00111 select pwm primary 1-4
// - codes 01110-10001 select pwm secondary 1-4
// - codes 10111-11010 select pwm current-limit 1-4
// - code 01100 timer1, code 11111 timer2
// - second register low slice drives pair 4 (9/8)
`timescale 1ns/100ps
module apt_pair_trigger_ctrl (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone classic slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // trigger sources
    input wire apt_pkg::apt_trig_type trig_i,
    // conversion core
    input wire logic conv_busy_i,
    input wire logic conv_done_i,
    output apt_pkg::apt_conv_type conv_o,
    // interrupt
    output logic irq_o
);

    // source decode; reserved codes simply never fire
    function automatic logic trig_select(input logic [4:0] src, input apt_pkg::apt_trig_type trg,
                                         input logic kick, input logic glob);
        logic [4:0] ofs;
        logic hit;
        ofs = 5'h00;
        hit = 1'b0;
        case (src)
            apt_pkg::SRC_OFF: hit = 1'b0;
            apt_pkg::SRC_SOFT: hit = kick;
            apt_pkg::SRC_GLOBAL: hit = glob;
            apt_pkg::SRC_SPECIAL: hit = trg.pwm_special;
            apt_pkg::SRC_TIMER1: hit = trg.timer1_period;
            apt_pkg::SRC_TIMER2: hit = trg.timer2_period;
            default: begin
                if (src >= apt_pkg::SRC_PRI_FIRST && src <= apt_pkg::SRC_PRI_LAST) begin
                    ofs = src - apt_pkg::SRC_PRI_FIRST;
                    hit = trg.pwm_primary[ofs[1:0]];
                end else if (src >= apt_pkg::SRC_SEC_FIRST && src <= apt_pkg::SRC_SEC_LAST) begin
                    ofs = src - apt_pkg::SRC_SEC_FIRST;
                    hit = trg.pwm_secondary[ofs[1:0]];
                end else if (src >= apt_pkg::SRC_CLIM_FIRST && src <= apt_pkg::SRC_CLIM_LAST) begin
                    ofs = src - apt_pkg::SRC_CLIM_FIRST;
                    hit = trg.pwm_climit[ofs[1:0]];
                end
            end
        endcase
        return hit;
    endfunction

    // lowest waiting pair wins the converter
    function automatic logic [1:0] pick_pair(input logic [3:0] req);
        logic [1:0] sel;
        sel = 2'h0;
        for (int k = apt_pkg::NUM_PAIRS - 1; k >= 0; k--) begin
            if (req[k]) begin
                sel = 2'(k);
            end
        end
        return sel;
    endfunction

    apt_pkg::apt_slice_type slice_ff [apt_pkg::NUM_PAIRS];
    logic ack_ff;
    logic [31:0] dat_ff;
    logic [3:0] irq_stat_ff;
    logic [3:0] irq_en_ff;
    logic glob_ff;
    apt_pkg::apt_state_type state_ff;
    logic [1:0] cur_pair_ff;
    apt_pkg::apt_conv_type conv_ff;
    logic req_go;
    logic wr_go;
    logic [3:0] hit;
    logic [3:0] waiting;
    logic [3:0] done_vec;
    logic [31:0] rd_mux;
    logic [1:0] nxt_pick;

    // bus decode; a write lands on the edge where the master sees ack
    assign req_go = wb_cyc_i & wb_stb_i & ~ack_ff;
    assign wr_go = wb_cyc_i & wb_stb_i & wb_we_i & ack_ff;
    assign wb_ack_o = ack_ff;
    assign wb_dat_o = dat_ff;

    // per-pair trigger, waiting and completion vectors
    always_comb begin
        for (int p = 0; p < apt_pkg::NUM_PAIRS; p++) begin
            hit[p] = trig_select(slice_ff[p].trigger_select, trig_i, slice_ff[p].soft_kick, glob_ff);
            waiting[p] = slice_ff[p].conv_waiting;
            done_vec[p] = (state_ff == apt_pkg::ST_CONV) && conv_done_i && (cur_pair_ff == 2'(p));
        end
    end

    assign nxt_pick = pick_pair(waiting);

    // read mux; unmapped and write-only offsets read zero
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (wb_adr_i)
            apt_pkg::OFF_CTRL_A: rd_mux = {16'h0000, slice_ff[1], slice_ff[0]};
            apt_pkg::OFF_CTRL_B: rd_mux = {16'h0000, slice_ff[3], slice_ff[2]};
            apt_pkg::OFF_IRQ_STAT: rd_mux = {28'h000_0000, irq_stat_ff};
            apt_pkg::OFF_IRQ_EN: rd_mux = {28'h000_0000, irq_en_ff};
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // ack one cycle after the request, dropped the cycle after
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= req_go;
        end
    end

    // read data captured with the request so it is stable under ack
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_ff <= 32'h0000_0000;
        end else if (req_go && !wb_we_i) begin
            dat_ff <= rd_mux;
        end
    end

    // control slices in one process so each slice array has a single driver
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int p = 0; p < apt_pkg::NUM_PAIRS; p++) begin
                slice_ff[p] <= apt_pkg::apt_slice_type'(apt_pkg::CTRL_RESET[7:0]);
            end
        end else begin
            for (int p = 0; p < apt_pkg::NUM_PAIRS; p++) begin
                // pairs 2,3 in the first register, pairs 4,5 in the second
                if (wr_go && wb_adr_i == (p < 2 ? apt_pkg::OFF_CTRL_A : apt_pkg::OFF_CTRL_B)
                    && wb_sel_i[p % 2]) begin
                    slice_ff[p].irq_enable <= wb_dat_i[(p % 2) * 8 + 7];
                    slice_ff[p].trigger_select <= wb_dat_i[(p % 2) * 8 +: 5];
                    // a new write beats the hardware self-clear so no kick is lost
                    slice_ff[p].soft_kick <= wb_dat_i[(p % 2) * 8 + 5];
                end else if (hit[p]) begin
                    slice_ff[p].soft_kick <= 1'b0;
                end
                // pending is hardware owned; a trigger beats a same-cycle completion
                if (hit[p]) begin
                    slice_ff[p].conv_waiting <= 1'b1;
                end else if (done_vec[p]) begin
                    slice_ff[p].conv_waiting <= 1'b0;
                end
            end
        end
    end

    // global kick strobe, one cycle, shared by all pairs
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            glob_ff <= 1'b0;
        end else begin
            glob_ff <= wr_go && wb_adr_i == apt_pkg::OFF_GLOBAL_KICK && wb_sel_i[0]
                       && wb_dat_i[apt_pkg::GLOBAL_KICK_BIT];
        end
    end

    // arbiter: waits while the core is busy, one conversion in flight
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_ff <= apt_pkg::ST_IDLE;
            cur_pair_ff <= 2'h0;
            conv_ff <= '0;
        end else begin
            conv_ff.start <= 1'b0;
            case (state_ff)
                apt_pkg::ST_IDLE: begin
                    if (|waiting && !conv_busy_i) begin
                        state_ff <= apt_pkg::ST_CONV;
                        cur_pair_ff <= nxt_pick;
                        conv_ff.start <= 1'b1;
                        conv_ff.pair <= apt_pkg::FIRST_PAIR + 4'(nxt_pick);
                        // pair n converts inputs 2n+1 and 2n
                        conv_ff.chan_lo <= 4'((apt_pkg::FIRST_PAIR + 4'(nxt_pick)) << 1);
                        conv_ff.chan_hi <= 4'(((apt_pkg::FIRST_PAIR + 4'(nxt_pick)) << 1) | 4'h1);
                    end
                end
                apt_pkg::ST_CONV: begin
                    if (conv_done_i) begin
                        state_ff <= apt_pkg::ST_IDLE;
                    end
                end
                default: state_ff <= apt_pkg::ST_IDLE;
            endcase
        end
    end

    assign conv_o = conv_ff;

    // sticky completion status, set wins over a clear write
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_stat_ff <= apt_pkg::IRQ_RESET;
        end else begin
            for (int p = 0; p < apt_pkg::NUM_PAIRS; p++) begin
                if (done_vec[p] && slice_ff[p].irq_enable) begin
                    irq_stat_ff[p] <= 1'b1;
                end else if (wr_go && wb_adr_i == apt_pkg::OFF_IRQ_CLR && wb_sel_i[0] && wb_dat_i[p]) begin
                    irq_stat_ff[p] <= 1'b0;
                end
            end
        end
    end

    // interrupt enable mask register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_en_ff <= apt_pkg::IRQ_RESET;
        end else if (wr_go && wb_adr_i == apt_pkg::OFF_IRQ_EN && wb_sel_i[0]) begin
            irq_en_ff <= wb_dat_i[3:0];
        end
    end

    // level interrupt while any enabled status bit stands
    assign irq_o = |(irq_stat_ff & irq_en_ff);

    // ---- assertions ----
    sequence s_bus_req;
        wb_cyc_i && wb_stb_i && !ack_ff;
    endsequence

    sequence s_start_taken;
        conv_ff.start ##1 (state_ff == apt_pkg::ST_CONV);
    endsequence

    a_ack_timing: assert property (@(posedge clk_i) disable iff (rst_i)
        s_bus_req |=> ack_ff ##1 !ack_ff)
        else $error("ack not a single cycle after request");

    a_pend_sets: assert property (@(posedge clk_i) disable iff (rst_i)
        hit[0] |=> slice_ff[0].conv_waiting)
        else $error("pending not set after trigger");

    a_kick_clears: assert property (@(posedge clk_i) disable iff (rst_i)
        (hit[0] && slice_ff[0].trigger_select == apt_pkg::SRC_SOFT && !wr_go)
        |=> !slice_ff[0].soft_kick && slice_ff[0].conv_waiting)
        else $error("soft kick not cleared as pending set");

    a_off_no_hit: assert property (@(posedge clk_i) disable iff (rst_i)
        slice_ff[2].trigger_select == apt_pkg::SRC_OFF |-> !hit[2])
        else $error("disabled pair triggered");

    a_busy_holds: assert property (@(posedge clk_i) disable iff (rst_i)
        (state_ff == apt_pkg::ST_IDLE && conv_busy_i) |=> !conv_ff.start)
        else $error("conversion started while core busy");

    a_start_channel: assert property (@(posedge clk_i) disable iff (rst_i)
        conv_ff.start |-> conv_ff.chan_lo == 4'(conv_ff.pair << 1) && conv_ff.chan_hi == conv_ff.chan_lo + 4'h1)
        else $error("wrong analog inputs for pair");

    a_start_state: assert property (@(posedge clk_i) disable iff (rst_i)
        (state_ff == apt_pkg::ST_IDLE && |waiting && !conv_busy_i) |=> s_start_taken)
        else $error("waiting pair not started when core free");

    a_irq_level: assert property (@(posedge clk_i) disable iff (rst_i)
        (done_vec[0] && slice_ff[0].irq_enable)
        |=> irq_stat_ff[0])
        else $error("interrupt status not set on completion");

    a_global_kick: assert property (@(posedge clk_i) disable iff (rst_i)
        (glob_ff && slice_ff[0].trigger_select == apt_pkg::SRC_GLOBAL
         && slice_ff[1].trigger_select == apt_pkg::SRC_GLOBAL) |-> hit[0] && hit[1])
        else $error("global kick did not reach all pairs");

    a_reset_zero: assert property (@(posedge clk_i)
        $past(rst_i) |-> slice_ff[0] == '0 && slice_ff[3] == '0 && !irq_o)
        else $error("control fields not zero after reset");

    // completion, decode and hold checks
    a_wait_clears: assert property (@(posedge clk_i) disable iff (rst_i)
        (done_vec[0] && !hit[0])
        |=> !slice_ff[0].conv_waiting)
        else $error("pending not cleared on completion");

    a_kick_ignored: assert property (@(posedge clk_i) disable iff (rst_i)
        (slice_ff[0].trigger_select == apt_pkg::SRC_GLOBAL && !glob_ff)
        |-> !hit[0])
        else $error("kick bit fired a pair off the soft source");

    a_irq_out: assert property (@(posedge clk_i) disable iff (rst_i)
        (irq_stat_ff[0] && irq_en_ff[0])
        |-> irq_o)
        else $error("interrupt low with enabled status set");

    a_irq_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
        (done_vec[1] && !slice_ff[1].irq_enable && !irq_stat_ff[1])
        |=> !irq_stat_ff[1])
        else $error("status set with irq enable field off");

    a_one_flight: assert property (@(posedge clk_i) disable iff (rst_i)
        (state_ff == apt_pkg::ST_CONV && !conv_done_i)
        |=> !conv_ff.start)
        else $error("second start while a conversion is in flight");

    a_done_idle: assert property (@(posedge clk_i) disable iff (rst_i)
        (state_ff == apt_pkg::ST_CONV && conv_done_i)
        |=> state_ff == apt_pkg::ST_IDLE)
        else $error("arbiter not idle after completion");

    a_pair_range: assert property (@(posedge clk_i) disable iff (rst_i)
        conv_ff.start
        |-> (conv_ff.pair - apt_pkg::FIRST_PAIR) < 4'(apt_pkg::NUM_PAIRS))
        else $error("start names a pair outside this block");

    a_start_waiting: assert property (@(posedge clk_i) disable iff (rst_i)
        conv_ff.start
        |-> waiting[cur_pair_ff])
        else $error("start for a pair with nothing pending");

    a_glob_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
        glob_ff
        |=> !glob_ff)
        else $error("global strobe longer than one cycle");

    a_src_keep: assert property (@(posedge clk_i) disable iff (rst_i)
        !wr_go
        |=> $stable(slice_ff[2].trigger_select))
        else $error("source field changed without a write");

    a_conv_hold: assert property (@(posedge clk_i) disable iff (rst_i)
        !conv_ff.start
        |-> $stable(conv_ff.pair) && $stable(conv_ff.chan_lo))
        else $error("pair or inputs moved between starts");

    a_ack_idle: assert property (@(posedge clk_i) disable iff (rst_i)
        !wb_cyc_i
        |=> !ack_ff)
        else $error("ack without a bus cycle");

    a_pri_hit: assert property (@(posedge clk_i) disable iff (rst_i)
        (slice_ff[3].trigger_select == apt_pkg::SRC_PRI_FIRST && trig_i.pwm_primary[0])
        |-> hit[3])
        else $error("primary trigger of generator 1 missed");

    a_sec_hit: assert property (@(posedge clk_i) disable iff (rst_i)
        (slice_ff[3].trigger_select == apt_pkg::SRC_SEC_LAST && trig_i.pwm_secondary[3])
        |-> hit[3])
        else $error("secondary trigger of generator 4 missed");

    a_clim_hit: assert property (@(posedge clk_i) disable iff (rst_i)
        (slice_ff[3].trigger_select == apt_pkg::SRC_CLIM_FIRST && trig_i.pwm_climit[0])
        |-> hit[3])
        else $error("current-limit trigger of generator 1 missed");

    a_timer2_hit: assert property (@(posedge clk_i) disable iff (rst_i)
        (slice_ff[3].trigger_select == apt_pkg::SRC_TIMER2 && trig_i.timer2_period)
        |-> hit[3])
        else $error("second timer trigger missed");

endmodule

// file: tb/apt_core_model.sv
// conversion core model: answers each start with a done pulse after a bench-set delay
`timescale 1ns/100ps
module apt_core_model (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // bench control: hold other work in flight, conversion length
    input wire logic hold_i,
    input wire logic [7:0] lat_i,
    // link to the trigger control
    input wire apt_pkg::apt_conv_type conv_i,
    output logic busy_o,
    output logic done_o
);
    logic [7:0] cnt_ff;

    // busy only for work the bench holds, so the block must wait, not drop
    assign busy_o = hold_i;

    // one conversion at a time; done never in the same cycle as start
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_ff <= 8'h00;
            done_o <= 1'b0;
        end else begin
            done_o <= (cnt_ff == 8'h01);
            if (conv_i.start) begin
                cnt_ff <= lat_i;
            end else if (cnt_ff != 8'h00) begin
                cnt_ff <= cnt_ff - 8'h01;
            end
        end
    end
endmodule

// file: tb/tb.sv
// testbench: register accesses, trigger pulses and conversion checks for the pair trigger control
`timescale 1ns/100ps
module tb;
    logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq_o, busy, done, hold;
    logic [7:0] wb_adr_i, lat;
    logic [31:0] wb_dat_i, wb_dat_o, rd;
    logic [3:0] wb_sel_i;
    logic [4:0] quiet_src [2];
    apt_pkg::apt_trig_type trig_i;
    apt_pkg::apt_conv_type conv_o;
    int n_mismatch, checks_done;

    apt_pair_trigger_ctrl u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .trig_i(trig_i), .conv_busy_i(busy), .conv_done_i(done), .conv_o(conv_o),
        .irq_o(irq_o));
    apt_core_model u_core (.clk_i(clk_i), .rst_i(rst_i), .hold_i(hold), .lat_i(lat), .conv_i(conv_o),
        .busy_o(busy), .done_o(done));

    // 25 MHz clock
    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end

    task automatic close_out();
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // one classic cycle, held until ack is sampled; read data taken at that edge
    task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat);
        int i;
        i = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= dat;
        do begin
            @(posedge clk_i);
            i++;
        end while (wb_ack_o !== 1'b1 && i < 20);
        if (i >= 20) n_mismatch++;
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp);
        wb_xfer(1'b0, adr, 32'h0);
        chk(rd, exp);
    endtask

    // one-cycle trigger pulse on the chosen sources
    task automatic pulse(input apt_pkg::apt_trig_type t);
        @(posedge clk_i);
        trig_i <= t;
        @(posedge clk_i);
        trig_i <= '0;
    endtask

    task automatic no_start(input int n);
        logic seen;
        seen = 1'b0;
        repeat (n) begin
            @(posedge clk_i);
            if (conv_o.start === 1'b1) seen = 1'b1;
        end
        chk(seen, 1'b0);
    endtask

    // wait for a start, check pair and inputs, then wait for its done edge
    task automatic conv_chk(input logic [3:0] p);
        int i;
        i = 0;
        do begin
            @(posedge clk_i);
            i++;
        end while (conv_o.start !== 1'b1 && i < 60);
        chk(conv_o.start, 1'b1);
        chk(conv_o.pair, p);
        chk(conv_o.chan_hi, {p[2:0], 1'b1});
        chk(conv_o.chan_lo, {p[2:0], 1'b0});
        i = 0;
        do begin
            @(posedge clk_i);
            i++;
        end while (done !== 1'b1 && i < 300);
    endtask

    // source table: 0 special, 1-4 primary, 5-8 secondary, 9-12 current limit, 13-14 timers
    function automatic apt_pkg::apt_trig_type src_of(input int k);
        apt_pkg::apt_trig_type t;
        t = '0;
        if (k == 0) t.pwm_special = 1'b1;
        else if (k < 5) t.pwm_primary[k - 1] = 1'b1;
        else if (k < 9) t.pwm_secondary[k - 5] = 1'b1;
        else if (k < 13) t.pwm_climit[k - 9] = 1'b1;
        else if (k == 13) t.timer1_period = 1'b1;
        else t.timer2_period = 1'b1;
        return t;
    endfunction

    function automatic logic [4:0] code_of(input int k);
        if (k == 0) return 5'h03;
        if (k < 5) return 5'h04 + 5'(k - 1);
        if (k < 9) return 5'h0E + 5'(k - 5);
        if (k < 13) return 5'h17 + 5'(k - 9);
        if (k == 13) return 5'h0C;
        return 5'h1F;
    endfunction

    // watchdog well beyond the several hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge clk_i);
        n_mismatch++;
        close_out();
    end

    initial begin
        rst_i = 1'b1;
        {wb_cyc_i, wb_stb_i, wb_we_i, hold} = 4'h0;
        wb_adr_i = 8'h00;
        wb_dat_i = 32'h0;
        wb_sel_i = 4'hF;
        trig_i = '0;
        lat = 8'h20;
        quiet_src = '{5'h00, 5'h02};
        n_mismatch = 0;
        checks_done = 0;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        // every mapped place and one unmapped read zero after reset
        for (int i = 0; i < 7; i++) rd_chk(8'(i * 4), 32'h0);
        wb_xfer(1'b1, apt_pkg::OFF_CTRL_B, 32'h0000FFFF);
        rd_chk(apt_pkg::OFF_CTRL_B, 32'h0000BFBF);
        wb_xfer(1'b1, apt_pkg::OFF_CTRL_B, 32'h0);
        // soft kick pair 2 with interrupt, slow core
        wb_xfer(1'b1, apt_pkg::OFF_IRQ_EN, 32'h1);
        wb_xfer(1'b1, apt_pkg::OFF_CTRL_A, 32'h000000A1);
        conv_chk(4'h2);
        @(posedge clk_i);
        chk(irq_o, 1'b1);
        rd_chk(apt_pkg::OFF_CTRL_A, 32'h81);
        rd_chk(apt_pkg::OFF_IRQ_STAT, 32'h1);
        wb_xfer(1'b1, apt_pkg::OFF_IRQ_EN, 32'h0);
        @(posedge clk_i);
        chk(irq_o, 1'b0);
        wb_xfer(1'b1, apt_pkg::OFF_IRQ_CLR, 32'h1);
        wb_xfer(1'b1, apt_pkg::OFF_IRQ_EN, 32'hF);
        rd_chk(apt_pkg::OFF_IRQ_STAT, 32'h0);
        // converter busy: request must wait, prompt core afterwards
        hold <= 1'b1;
        lat <= 8'h02;
        wb_xfer(1'b1, apt_pkg::OFF_CTRL_A, 32'h21);
        no_start(10);
        rd_chk(apt_pkg::OFF_CTRL_A, 32'h41);
        hold <= 1'b0;
        conv_chk(4'h2);
        rd_chk(apt_pkg::OFF_CTRL_A, 32'h01);
        // kick bit ignored off code 00001; global strobe starts both pairs
        wb_xfer(1'b1, apt_pkg::OFF_CTRL_A, 32'h0222);
        no_start(8);
        rd_chk(apt_pkg::OFF_CTRL_A, 32'h0222);
        wb_xfer(1'b1, apt_pkg::OFF_GLOBAL_KICK, 32'h1);
        conv_chk(4'h2);
        conv_chk(4'h3);
        rd_chk(apt_pkg::OFF_IRQ_STAT, 32'h0);
        wb_xfer(1'b1, apt_pkg::OFF_CTRL_A, 32'h0);
        wb_xfer(1'b1, apt_pkg::OFF_CTRL_B, 32'h21);
        conv_chk(4'h4);
        // each hardware source on pair 5: all others first, then the chosen one
        for (int k = 0; k < 15; k++) begin
            wb_xfer(1'b1, apt_pkg::OFF_CTRL_B, {16'h0, 3'b000, code_of(k), 8'h00});
            pulse(~src_of(k));
            no_start(8);
            pulse(src_of(k));
            conv_chk(4'h5);
        end
        // off, and global without its strobe, never start whatever fires; reserved codes stay unused
        foreach (quiet_src[j]) begin
            wb_xfer(1'b1, apt_pkg::OFF_CTRL_B, {16'h0, 3'b001, quiet_src[j], 8'h00});
            pulse('1);
            no_start(8);
        end
        close_out();
    end
endmodule
